//--- hdl/data_move_pkg.sv
package data_move_pkg;

  // ----------------------------------------------------------------
  // instruction encodings
  // ----------------------------------------------------------------
  localparam logic [9:0] OP_PTR_LOAD = 10'h3B8;
  localparam logic [7:0] OP_PTR_LOAD2 = 8'hF0;
  localparam logic [5:0] OP_REG_MOVE = 6'h14;
  localparam logic [3:0] OP_FILE_MOVE = 4'hC;
  localparam logic [3:0] OP_FILE_MOVE2 = 4'hF;
  localparam logic [7:0] OP_BANK_LOAD = 8'h01;

  // ----------------------------------------------------------------
  // addressing
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_LIMIT = 8'h5F;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_HI_PAGE = 4'hF;
  localparam logic [11:0] ADDR_PC_LOW = 12'hFF9;
  localparam logic [11:0] ADDR_TOS_LOW = 12'hFFD;
  localparam logic [11:0] ADDR_TOS_HIGH = 12'hFFE;
  localparam logic [11:0] ADDR_TOS_UPPER = 12'hFFF;
  localparam int NUM_POINTERS = 3;

  // ----------------------------------------------------------------
  // register port map
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_WORK = 4'h2;
  localparam logic [3:0] REG_BANK = 4'h3;
  localparam logic [3:0] REG_PTR_BASE = 4'h4;
  localparam int CTRL_EXT_BIT = 0;
  localparam int STAT_ZERO_BIT = 0;
  localparam int STAT_NEG_BIT = 1;
  localparam int STAT_ILLEGAL_BIT = 2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [11:0] RST_PTR = 12'h000;

  typedef struct packed {
    logic rdEn;
    logic wrEn;
    logic [11:0] addr;
    logic [7:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic write;
    logic read;
  } reg_req_t;

endpackage : data_move_pkg

//--- hdl/data_move_exec.sv
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps

// Contract
// - pointer load: two words, two cycles, high nibble then low byte
// - register move: direction 0 to work register, 1 back to source
// - register move file address spans a whole 256-byte bank
// - bank bit 1 uses bank select, bank bit 0 uses access bank
// - extended set, bank bit 0, address up to 5Fh: indexed offset
// - file move: 12-bit source and destination across 4096 bytes
// - bank load writes literal in one cycle, upper nibble reads zero
module data_move_exec (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // instruction stream
  input wire logic instrValid,
  input wire logic [15:0] instrWord,
  output logic instrReady,
  // data memory, read data one cycle after the request
  output data_move_pkg::mem_req_t memReq,
  input wire logic [7:0] memRdata,
  // register port
  input data_move_pkg::reg_req_t regReq,
  output logic [7:0] regRdata,
  // core state
  output logic [7:0] workReg,
  output logic [7:0] bankSelect,
  output logic busy
);
  import data_move_pkg::*;
  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic isPtrLoad(input logic [15:0] w);
    isPtrLoad = (w[15:6] == OP_PTR_LOAD);
  endfunction : isPtrLoad
  function automatic logic isRegMove(input logic [15:0] w);
    isRegMove = (w[15:10] == OP_REG_MOVE);
  endfunction : isRegMove
  function automatic logic isFileMove(input logic [15:0] w);
    isFileMove = (w[15:12] == OP_FILE_MOVE);
  endfunction : isFileMove
  function automatic logic isBankLoad(input logic [15:0] w);
    isBankLoad = (w[15:8] == OP_BANK_LOAD);
  endfunction : isBankLoad
  function automatic logic [11:0] effAddr(input logic [7:0] f,
    input logic a, input logic ext, input logic [7:0] bank_select_reg,
    input logic [11:0] ptr2);
    if (a) begin
      effAddr = {bank_select_reg[3:0], f};
    end else if (ext && f <= IDX_LIMIT) begin
      effAddr = ptr2 + {4'h0, f};
    end else if (f < ACCESS_SPLIT) begin
      effAddr = {4'h0, f};
    end else begin
      effAddr = {ACCESS_HI_PAGE, f};
    end
  endfunction : effAddr
  function automatic logic isProtected(input logic [11:0] a);
    isProtected = (a == ADDR_PC_LOW) || (a == ADDR_TOS_LOW) ||
                  (a == ADDR_TOS_HIGH) || (a == ADDR_TOS_UPPER);
  endfunction : isProtected
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE, S_PTR_LOW, S_REG_MOVE, S_FILE_CAP, S_FILE_DEST
  } state_t;
  state_t state_q;
  logic [11:0] ptr_q [NUM_POINTERS];
  logic [1:0] ptrSel_q;
  logic dir_q;
  logic [11:0] addr_q;
  logic [7:0] data_q;
  logic [7:0] work_q;
  logic [7:0] bank_q;
  logic zero_q;
  logic neg_q;
  logic illegal_q;
  logic ext_q;
  logic [7:0] rdata_q;
  logic [11:0] decAddr;
  logic illegalSet;
  assign decAddr = effAddr(instrWord[7:0], instrWord[8], ext_q, bank_q,
                           ptr_q[2]);
  assign instrReady = (state_q == S_IDLE) || (state_q == S_PTR_LOW) ||
                      (state_q == S_FILE_DEST);
  assign busy = (state_q != S_IDLE);
  assign workReg = work_q;
  assign bankSelect = bank_q;
  assign regRdata = rdata_q;
  assign illegalSet = (state_q == S_FILE_DEST) && instrValid &&
                      isProtected(instrWord[11:0]);

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!nrst) begin
      state_q <= S_IDLE;
    end else begin
      unique case (state_q)
        S_IDLE: begin
          if (instrValid) begin
            if (isPtrLoad(instrWord)) begin
              state_q <= S_PTR_LOW;
            end else if (isRegMove(instrWord)) begin
              state_q <= S_REG_MOVE;
            end else if (isFileMove(instrWord)) begin
              state_q <= S_FILE_CAP;
            end
          end
        end
        S_PTR_LOW, S_FILE_DEST: begin
          if (instrValid) begin
            state_q <= S_IDLE;
          end
        end
        S_REG_MOVE: state_q <= S_IDLE;
        S_FILE_CAP: state_q <= S_FILE_DEST;
      endcase
    end
  end
  // operand capture for the multi-cycle operations
  always_ff @(posedge clock) begin
    if (!nrst) begin
      ptrSel_q <= 2'h0;
      dir_q <= 1'b1;
      addr_q <= RST_PTR;
    end else if (state_q == S_IDLE && instrValid) begin
      ptrSel_q <= instrWord[5:4];
      dir_q <= instrWord[9];
      addr_q <= isFileMove(instrWord) ? instrWord[11:0]
                                      : decAddr;
    end
  end
  // source byte held between the two file move cycles
  always_ff @(posedge clock) begin
    if (!nrst) begin
      data_q <= RST_BYTE;
    end else if (state_q == S_FILE_CAP) begin
      data_q <= memRdata;
    end
  end

  // ----------------------------------------------------------------
  // pointers
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NUM_POINTERS; i++) begin : g_ptr
    always_ff @(posedge clock) begin
      if (!nrst) begin
        ptr_q[i] <= RST_PTR;
      end else if (state_q == S_IDLE && instrValid &&
                   isPtrLoad(instrWord) && instrWord[5:4] == i) begin
        ptr_q[i] <= {instrWord[3:0], ptr_q[i][7:0]};
      end else if (state_q == S_PTR_LOW && instrValid &&
                   ptrSel_q == i) begin
        ptr_q[i] <= {ptr_q[i][11:8], instrWord[7:0]};
      end
    end
  end
  // ----------------------------------------------------------------
  // work register, flags, bank select
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!nrst) begin
      work_q <= RST_BYTE;
    end else if (state_q == S_REG_MOVE && !dir_q) begin
      work_q <= memRdata;
    end
  end
  always_ff @(posedge clock) begin
    if (!nrst) begin
      zero_q <= 1'b0;
      neg_q <= 1'b0;
    end else if (state_q == S_REG_MOVE) begin
      zero_q <= (memRdata == RST_BYTE);
      neg_q <= memRdata[7];
    end
  end
  always_ff @(posedge clock) begin
    if (!nrst) begin
      bank_q <= RST_BYTE;
    end else if (state_q == S_IDLE && instrValid &&
                 isBankLoad(instrWord)) begin
      bank_q <= {4'h0, instrWord[3:0]};
    end
  end
  // ----------------------------------------------------------------
  // data memory request
  // ----------------------------------------------------------------
  always_comb begin
    memReq = '0;
    if (state_q == S_IDLE && instrValid) begin
      memReq.rdEn = isRegMove(instrWord) || isFileMove(instrWord);
      memReq.addr = isFileMove(instrWord) ? instrWord[11:0]
                                          : decAddr;
    end else if (state_q == S_REG_MOVE && dir_q) begin
      memReq.wrEn = 1'b1;
      memReq.addr = addr_q;
      memReq.wdata = memRdata;
    end else if (state_q == S_FILE_DEST && instrValid) begin
      // protected targets are dropped rather than corrupt control flow
      memReq.wrEn = !isProtected(instrWord[11:0]);
      memReq.addr = instrWord[11:0];
      memReq.wdata = data_q;
    end
  end
  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!nrst) begin
      ext_q <= 1'b0;
    end else if (regReq.write && regReq.addr == REG_CTRL) begin
      ext_q <= regReq.wdata[CTRL_EXT_BIT];
    end
  end
  // sticky; a new event wins over a write-one clear
  always_ff @(posedge clock) begin
    if (!nrst) begin
      illegal_q <= 1'b0;
    end else if (illegalSet) begin
      illegal_q <= 1'b1;
    end else if (regReq.write && regReq.addr == REG_STATUS &&
                 regReq.wdata[STAT_ILLEGAL_BIT]) begin
      illegal_q <= 1'b0;
    end
  end
  always_ff @(posedge clock) begin
    if (!nrst) begin
      rdata_q <= RST_BYTE;
    end else if (regReq.read) begin
      rdata_q <= RST_BYTE;
      unique case (regReq.addr)
        REG_CTRL: rdata_q[CTRL_EXT_BIT] <= ext_q;
        REG_STATUS: begin
          rdata_q[STAT_ZERO_BIT] <= zero_q;
          rdata_q[STAT_NEG_BIT] <= neg_q;
          rdata_q[STAT_ILLEGAL_BIT] <= illegal_q;
        end
        REG_WORK: rdata_q <= work_q;
        REG_BANK: rdata_q <= bank_q;
        REG_PTR_BASE: rdata_q <= ptr_q[0][7:0];
        REG_PTR_BASE + 4'h1: rdata_q <= {4'h0, ptr_q[0][11:8]};
        REG_PTR_BASE + 4'h2: rdata_q <= ptr_q[1][7:0];
        REG_PTR_BASE + 4'h3: rdata_q <= {4'h0, ptr_q[1][11:8]};
        REG_PTR_BASE + 4'h4: rdata_q <= ptr_q[2][7:0];
        REG_PTR_BASE + 4'h5: rdata_q <= {4'h0, ptr_q[2][11:8]};
        default: rdata_q <= RST_BYTE;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence s_ptrFirst;
    state_q == S_IDLE && instrValid && isPtrLoad(instrWord) &&
      instrWord[5:4] != 2'h3;
  endsequence
  property p_ptrHigh;
    s_ptrFirst |=> state_q == S_PTR_LOW &&
      ptr_q[ptrSel_q % NUM_POINTERS][11:8] == $past(instrWord[3:0]);
  endproperty
  a_ptrHigh: assert property (p_ptrHigh)
    else $error("pointer high byte not loaded");
  property p_ptrLow;
    state_q == S_PTR_LOW && instrValid && ptrSel_q < 2'h3 |=>
      state_q == S_IDLE &&
      ptr_q[$past(ptrSel_q) % NUM_POINTERS][7:0] == $past(instrWord[7:0]);
  endproperty
  a_ptrLow: assert property (p_ptrLow)
    else $error("pointer low byte not loaded");
  property p_moveToWork;
    state_q == S_REG_MOVE && !dir_q |=> work_q == $past(memRdata);
  endproperty
  a_moveToWork: assert property (p_moveToWork)
    else $error("register move did not reach work register");
  property p_moveBack;
    state_q == S_REG_MOVE && dir_q |-> memReq.wrEn &&
      memReq.addr == addr_q && memReq.wdata == memRdata && $stable(work_q);
  endproperty
  a_moveBack: assert property (p_moveBack)
    else $error("register move did not write back");
  property p_banked;
    state_q == S_IDLE && instrValid && isRegMove(instrWord) &&
      instrWord[8] |-> memReq.addr == {bank_q[3:0], instrWord[7:0]};
  endproperty
  a_banked: assert property (p_banked)
    else $error("banked address wrong");
  property p_indexed;
    state_q == S_IDLE && instrValid && isRegMove(instrWord) &&
      !instrWord[8] && ext_q && instrWord[7:0] <= IDX_LIMIT |->
      memReq.addr == ptr_q[2] + {4'h0, instrWord[7:0]};
  endproperty
  a_indexed: assert property (p_indexed)
    else $error("indexed offset address wrong");
  property p_flags;
    state_q == S_REG_MOVE |=> zero_q == ($past(memRdata) == 8'h00) &&
      neg_q == $past(memRdata[7]);
  endproperty
  a_flags: assert property (p_flags)
    else $error("move flags wrong");
  property p_bankLoad;
    state_q == S_IDLE && instrValid && isBankLoad(instrWord) |=>
      bank_q == {4'h0, $past(instrWord[3:0])} && bank_q[7:4] == 4'h0;
  endproperty
  a_bankLoad: assert property (p_bankLoad)
    else $error("bank load wrong");
  sequence s_fileRead;
    state_q == S_IDLE && instrValid && isFileMove(instrWord) &&
      memReq.rdEn && memReq.addr == instrWord[11:0];
  endsequence
  property p_fileMove;
    s_fileRead |=> state_q == S_FILE_CAP ##1
      state_q == S_FILE_DEST && data_q == $past(memRdata);
  endproperty
  a_fileMove: assert property (p_fileMove)
    else $error("file move source not captured");
  property p_noDummyRead;
    state_q == S_FILE_DEST |-> !memReq.rdEn &&
      (!instrValid || memReq.wdata == data_q);
  endproperty
  a_noDummyRead: assert property (p_noDummyRead)
    else $error("file move second cycle read or bad data");
  property p_protected;
    illegalSet |-> !memReq.wrEn ##1 illegal_q;
  endproperty
  a_protected: assert property (p_protected)
    else $error("protected destination written");
endmodule : data_move_exec

//--- bench/data_move_exec_tb_top.sv
`timescale 1ns/1ps

module data_move_exec_tb_top;
  import data_move_pkg::*;

  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic instrValid = 1'b0;
  logic [15:0] instrWord = 16'h0000;
  logic instrReady;
  mem_req_t memReq;
  logic [7:0] memRdata = 8'h00;
  reg_req_t regReq = '0;
  logic [7:0] regRdata;
  logic [7:0] workReg;
  logic [7:0] bankSelect;
  logic busy;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  logic [7:0] rv;

  // ----------------------------------------------------------------
  // clock, design, hang guard
  // ----------------------------------------------------------------
  always #10 clock = ~clock;

  data_move_exec dut (
    .clock(clock), .nrst(nrst), .instrValid(instrValid),
    .instrWord(instrWord), .instrReady(instrReady), .memReq(memReq),
    .memRdata(memRdata), .regReq(regReq), .regRdata(regRdata),
    .workReg(workReg), .bankSelect(bankSelect), .busy(busy)
  );

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches = mismatches + 1;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] got,
                     input logic [15:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  task automatic issue(input logic [15:0] w);
    @(posedge clock);
    instrValid <= 1'b1;
    instrWord <= w;
    @(negedge clock);
  endtask : issue

  task automatic idle();
    @(posedge clock);
    instrValid <= 1'b0;
  endtask : idle

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    regReq <= '{addr: a, wdata: 8'h00, write: 1'b0, read: 1'b1};
    @(posedge clock);
    regReq <= '0;
    @(negedge clock);
    d = regRdata;
  endtask : rd

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    regReq <= '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
    @(posedge clock);
    regReq <= '0;
  endtask : wr

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_bank();
    issue(16'h01FA);
    idle();
    @(negedge clock);
    chk("bankSelect", 16'(bankSelect), 16'h000A);
    rd(REG_BANK, rv);
    chk("bank reg", 16'(rv), 16'h000A);
  endtask : t_bank

  task automatic t_ptr();
    issue(16'hEE23);
    idle();
    rd(REG_PTR_BASE + 4'h5, rv);
    chk("ptr hi", 16'(rv), 16'h0003);
    rd(REG_PTR_BASE + 4'h4, rv);
    chk("ptr lo early", 16'(rv), 16'h0000);
    issue(16'hF0AB);
    idle();
    rd(REG_PTR_BASE + 4'h4, rv);
    chk("ptr lo", 16'(rv), 16'h00AB);
    // select 3 names no pointer: nothing may change
    issue(16'hEE35);
    idle();
    issue(16'hF077);
    idle();
    rd(REG_PTR_BASE + 4'h1, rv);
    chk("ptr0 hi", 16'(rv), 16'h0000);
    rd(REG_PTR_BASE, rv);
    chk("ptr0 lo", 16'(rv), 16'h0000);
    rd(REG_PTR_BASE + 4'h4, rv);
    chk("ptr2 lo kept", 16'(rv), 16'h00AB);
  endtask : t_ptr

  task automatic t_move(input logic [15:0] w, input logic [11:0] a,
                        input logic [7:0] v);
    logic [7:0] wOld;
    wOld = workReg;
    issue(w);
    chk("move rdEn", 16'(memReq.rdEn), 16'h0001);
    chk("move addr", 16'(memReq.addr), 16'(a));
    idle();
    memRdata <= v;
    @(negedge clock);
    chk("move busy", 16'(busy), 16'h0001);
    chk("wb wrEn", 16'(memReq.wrEn), 16'(w[9]));
    if (w[9]) begin
      chk("wb addr", 16'(memReq.addr), 16'(a));
      chk("wb data", 16'(memReq.wdata), 16'(v));
    end
    @(posedge clock);
    memRdata <= ~v;
    @(negedge clock);
    chk("workReg", 16'(workReg), 16'(w[9] ? wOld : v));
    rd(REG_WORK, rv);
    chk("work reg", 16'(rv), 16'(w[9] ? wOld : v));
    rd(REG_STATUS, rv);
    chk("flags", 16'(rv[1:0]), 16'({v[7], v == 8'h00}));
  endtask : t_move

  task automatic t_file(input logic [11:0] s, input logic [11:0] d,
                        input logic [7:0] v, input logic ok);
    issue({4'hC, s});
    chk("ff rd addr", 16'(memReq.addr), 16'(s));
    chk("ff rdEn", 16'(memReq.rdEn), 16'h0001);
    idle();
    memRdata <= v;
    @(negedge clock);
    chk("ff no read", 16'(memReq.rdEn), 16'h0000);
    @(posedge clock);
    instrValid <= 1'b1;
    instrWord <= {4'hF, d};
    memRdata <= ~v;
    @(negedge clock);
    chk("ff no dummy", 16'(memReq.rdEn), 16'h0000);
    chk("ff wrEn", 16'(memReq.wrEn), 16'(ok));
    if (ok) begin
      chk("ff wr addr", 16'(memReq.addr), 16'(d));
      chk("ff wr data", 16'(memReq.wdata), 16'(v));
    end
    idle();
    rd(REG_STATUS, rv);
    chk("illegal flag", 16'(rv[2]), 16'(!ok));
  endtask : t_file

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  logic [15:0] mw [8] = '{16'h51FF, 16'h5310, 16'h5070, 16'h5020,
                          16'h5005, 16'h505F, 16'h5060, 16'h5105};
  logic [11:0] ma [8] = '{12'hAFF, 12'hA10, 12'hF70, 12'h020,
                          12'h3B0, 12'h40A, 12'hF60, 12'hA05};
  logic [7:0] mv [8] = '{8'h80, 8'h00, 8'h7F, 8'h01,
                         8'h11, 8'h22, 8'h33, 8'h44};

  initial begin
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    @(negedge clock);
    chk("reset ready", 16'(instrReady), 16'h0001);
    chk("reset busy", 16'(busy), 16'h0000);
    chk("reset bank", 16'(bankSelect), 16'h0000);
    t_bank();
    t_ptr();
    for (int i = 0; i < 8; i++) begin
      if (i == 4) begin
        wr(REG_CTRL, 8'h01);
        rd(REG_CTRL, rv);
        chk("ctrl", 16'(rv), 16'h0001);
      end
      t_move(mw[i], ma[i], mv[i]);
    end
    t_file(12'hFFF, 12'h000, 8'h5A, 1'b1);
    t_file(12'h123, ADDR_PC_LOW, 8'hC3, 1'b0);
    wr(REG_STATUS, 8'h04);
    rd(REG_STATUS, rv);
    chk("illegal clear", 16'(rv[2]), 16'h0000);
    give_verdict();
  end

endmodule : data_move_exec_tb_top
